// File: logic/hbgc_pkg.sv
// Functional notes
// [RULE1] switching starts only on enable rising edge with both supplies good.
// [RULE2] mid-level input held 50ns: high side off, low side into diode emulation.
// [RULE3] mid level is driven or released; released input is pulled to mid internally.
// [RULE4] diode emulation, input low or mid: low side on while current positive.
// [RULE5] diode emulation: low side off on negative current or after zero crossing.
// [RULE6] diode emulation enabled by active-low request or mid-level input.
// [RULE7] high-side over-current four consecutive cycles latches high side off, fault low.
// [RULE8] after over-current latch, low side on until zero current, then both off.
// [RULE9] latches clear only on supply recycle or enable toggle.
// [RULE10] negative current trip forces low side off 40ns, then normal control.
// [RULE11] negative current limit never reports fault nor latches.
// [RULE12] over-temperature latches high side off, fault low, low side until zero.
// [RULE13] phase-to-ground short latches high side off, fault low.
// [RULE14] open-drain active-low fault pulled low while any latch is active.
// [RULE15] enable low disables: both switches off, phase node high impedance.
// [RULE16] fault stays released until the fourth consecutive limited cycle.
// [RULE17] input classified high, low or mid each cycle from three comparators.
// [RULE18] over-current count clears on a cycle completing without over-current.
package hbgc_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned MID_WINDOW_NS = 50;
   localparam int unsigned NEG_BLANK_NS = 40;
   // least times round up
   localparam int unsigned MID_WINDOW_CYC = (MID_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned NEG_BLANK_CYC = (NEG_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned OC_LIMIT_CYCLES = 4;
   localparam logic [3:0] MID_CNT_RST = 4'h0;
   localparam logic [3:0] NEG_CNT_RST = 4'h0;
   localparam logic [2:0] OC_CNT_RST = 3'h0;
   // synchroniser reset keeps the active-low emulation request idle high
   localparam logic [13:0] SYNC_RST = 14'h0040;

   typedef enum logic [1:0] {HBGC_PWM_LOW, HBGC_PWM_MID, HBGC_PWM_HIGH} hbgc_level_e;
   typedef enum logic [1:0] {HBGC_OFF, HBGC_RUN, HBGC_DRAIN, HBGC_HALT} hbgc_state_e;

   function automatic hbgc_level_e hbgc_classify(input logic above_high, input logic below_low);
      if (above_high)
         return HBGC_PWM_HIGH;
      else if (below_low)
         return HBGC_PWM_LOW;
      else
         return HBGC_PWM_MID;
   endfunction
endpackage

// File: logic/hbgc_sync_if.sv
interface hbgc_sync_if;
   logic pwm_above_high;
   logic pwm_below_low;
   logic pwm_released;
   logic enable;
   logic logic_supply_good;
   logic driver_supply_good;
   logic diode_emu_req_n;
   logic current_positive;
   logic current_negative;
   logic zero_cross;
   logic hs_over_current;
   logic ls_neg_limit;
   logic over_temp;
   logic phase_short;
   modport src (output pwm_above_high, pwm_below_low, pwm_released, enable, logic_supply_good,
      driver_supply_good, diode_emu_req_n, current_positive, current_negative, zero_cross,
      hs_over_current, ls_neg_limit, over_temp, phase_short);
   modport dst (input pwm_above_high, pwm_below_low, pwm_released, enable, logic_supply_good,
      driver_supply_good, diode_emu_req_n, current_positive, current_negative, zero_cross,
      hs_over_current, ls_neg_limit, over_temp, phase_short);
endinterface

// File: logic/hbgc_sync.sv
// two-flop synchroniser for all comparator and pin inputs
module hbgc_sync
   import hbgc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // raw inputs
   input wire logic [13:0] raw,
   // synchronised outputs
   hbgc_sync_if.src sy
);
   logic [13:0] meta_r;
   logic [13:0] sync_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_r <= SYNC_RST;
         sync_r <= SYNC_RST;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end
   assign sy.pwm_above_high = sync_r[0];
   assign sy.pwm_below_low = sync_r[1];
   assign sy.pwm_released = sync_r[2];
   assign sy.enable = sync_r[3];
   assign sy.logic_supply_good = sync_r[4];
   assign sy.driver_supply_good = sync_r[5];
   // request idles high through reset
   assign sy.diode_emu_req_n = sync_r[6];
   assign sy.current_positive = sync_r[7];
   assign sy.current_negative = sync_r[8];
   assign sy.zero_cross = sync_r[9];
   assign sy.hs_over_current = sync_r[10];
   assign sy.ls_neg_limit = sync_r[11];
   assign sy.over_temp = sync_r[12];
   assign sy.phase_short = sync_r[13];
endmodule // hbgc_sync

// File: logic/hbgc_top.sv
module hbgc_top
   import hbgc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pulse-width input comparators
   input wire logic pwm_above_high,
   input wire logic pwm_below_low,
   input wire logic pwm_released,
   // control pins and supply monitors
   input wire logic enable,
   input wire logic logic_supply_good,
   input wire logic driver_supply_good,
   input wire logic diode_emu_req_n,
   // analog comparator results
   input wire logic current_positive,
   input wire logic current_negative,
   input wire logic zero_cross,
   input wire logic hs_over_current,
   input wire logic ls_neg_limit,
   input wire logic over_temp,
   input wire logic phase_short,
   // switch commands
   output logic high_side_switch_on,
   output logic low_side_switch_on,
   output logic mid_pull_en,
   // open-drain fault report
   output logic fault_n_out,
   output logic fault_n_oe_n
);
   hbgc_sync_if sy ();

   hbgc_sync u_sync (
      .clock(clock),
      .rst(rst),
      .raw({phase_short, over_temp, ls_neg_limit, hs_over_current, zero_cross, current_negative,
         current_positive, diode_emu_req_n, driver_supply_good, logic_supply_good, enable,
         pwm_released, pwm_below_low, pwm_above_high}),
      .sy(sy)
   );

   hbgc_state_e state_r, state_nxt;
   logic en_prev_r;
   logic [3:0] mid_cnt_r;
   logic [3:0] neg_cnt_r;
   logic [2:0] oc_cnt_r;
   logic oc_seen_r;
   logic hs_prev_r;
   logic fault_oe_n_r;
   logic mid_pull_r;
   logic fault_drive_r;
   logic zc_done_r;
   logic hs_r, ls_r;

   wire supplies_ok = sy.logic_supply_good & sy.driver_supply_good;
   wire en_rise = sy.enable & ~en_prev_r & supplies_ok; // [RULE1]
   // disable or supply loss releases every latch
   wire clear_all = ~sy.enable | ~supplies_ok; // [RULE9] [RULE15]
   hbgc_level_e lvl;
   assign lvl = hbgc_classify(sy.pwm_above_high, sy.pwm_below_low); // [RULE17]
   wire is_mid = (lvl == HBGC_PWM_MID) | sy.pwm_released; // [RULE3]
   wire mid_held = is_mid && (mid_cnt_r >= 4'(MID_WINDOW_CYC)); // [RULE2]
   wire de_mode = ~sy.diode_emu_req_n | mid_held; // [RULE6]
   wire neg_block = (neg_cnt_r != NEG_CNT_RST); // [RULE10]
   wire cycle_end = hs_prev_r & ~hs_r;
   wire oc_trip = cycle_end && oc_seen_r && (oc_cnt_r == 3'(OC_LIMIT_CYCLES - 1)); // [RULE7]
   wire latch_ev = oc_trip | sy.over_temp | sy.phase_short; // [RULE12] [RULE13]
   wire drain_ev = oc_trip | sy.over_temp;

   // low-side diode emulation: on while positive, off on negative or after zero crossing
   wire de_ls = sy.current_positive & ~sy.current_negative & ~zc_done_r; // [RULE4] [RULE5]
   wire run_hs = (lvl == HBGC_PWM_HIGH) & ~mid_held;
   wire run_ls = de_mode ? ((lvl != HBGC_PWM_HIGH) & de_ls) : (lvl == HBGC_PWM_LOW);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HBGC_OFF: if (en_rise) state_nxt = HBGC_RUN;
         HBGC_RUN: begin
            if (clear_all) state_nxt = HBGC_OFF;
            else if (drain_ev) state_nxt = HBGC_DRAIN; // [RULE8]
            else if (latch_ev) state_nxt = HBGC_HALT;
         end
         HBGC_DRAIN: begin
            if (clear_all) state_nxt = HBGC_OFF;
            else if (sy.zero_cross | ~sy.current_positive) state_nxt = HBGC_HALT; // [RULE8]
         end
         HBGC_HALT: if (clear_all) state_nxt = HBGC_OFF; // [RULE9]
         default: state_nxt = HBGC_OFF;
      endcase
   end

   wire hs_nxt = (state_r == HBGC_RUN) && (state_nxt == HBGC_RUN) && run_hs;
   wire ls_want = ((state_r == HBGC_RUN) && (state_nxt == HBGC_RUN) && run_ls && ~run_hs)
      || ((state_nxt == HBGC_DRAIN) && sy.current_positive);
   wire ls_nxt = ls_want & ~neg_block & ~sy.ls_neg_limit; // [RULE10] [RULE11]
   wire fault_nxt = (state_nxt == HBGC_DRAIN) || (state_nxt == HBGC_HALT); // [RULE14] [RULE16]

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= HBGC_OFF;
         en_prev_r <= 1'b0;
         hs_r <= 1'b0;
         ls_r <= 1'b0;
         hs_prev_r <= 1'b0;
         fault_oe_n_r <= 1'b1;
         mid_pull_r <= 1'b1;
         fault_drive_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         en_prev_r <= sy.enable;
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
         hs_prev_r <= hs_r;
         fault_oe_n_r <= ~fault_nxt;
         mid_pull_r <= 1'b1;
         fault_drive_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst)
         mid_cnt_r <= MID_CNT_RST;
      else if (!is_mid)
         mid_cnt_r <= MID_CNT_RST;
      else if (mid_cnt_r < 4'(MID_WINDOW_CYC))
         mid_cnt_r <= mid_cnt_r + 4'h1; // [RULE2]
   end

   // negative limit blanks the low side for a fixed time, no latch
   always_ff @(posedge clock) begin
      if (rst)
         neg_cnt_r <= NEG_CNT_RST;
      else if (sy.ls_neg_limit)
         neg_cnt_r <= 4'(NEG_BLANK_CYC); // [RULE10]
      else if (neg_block)
         neg_cnt_r <= neg_cnt_r - 4'h1;
   end

   // zero crossing seen since the current last went positive; a stale mark must not block a new pulse
   always_ff @(posedge clock) begin
      if (rst)
         zc_done_r <= 1'b0;
      else if (hs_r | ~de_mode | ~sy.current_positive)
         zc_done_r <= 1'b0;
      else if (ls_r & sy.zero_cross)
         zc_done_r <= 1'b1; // [RULE5]
   end

   // consecutive over-current cycles, counted at each high-side turn-off
   always_ff @(posedge clock) begin
      if (rst) begin
         oc_seen_r <= 1'b0;
         oc_cnt_r <= OC_CNT_RST;
      end else if (state_r != HBGC_RUN) begin
         oc_seen_r <= 1'b0;
         oc_cnt_r <= OC_CNT_RST;
      end else if (cycle_end) begin
         oc_seen_r <= hs_r & sy.hs_over_current;
         if (oc_seen_r)
            oc_cnt_r <= oc_cnt_r + 3'h1; // [RULE7]
         else
            oc_cnt_r <= OC_CNT_RST; // [RULE18]
      end else if (hs_r & sy.hs_over_current) begin
         oc_seen_r <= 1'b1;
      end
   end

   assign high_side_switch_on = hs_r;
   assign low_side_switch_on = ls_r;
   // internal source holds a released input at mid level
   assign mid_pull_en = mid_pull_r; // [RULE3]
   // open-drain pin: drive value stays low, the enable decides
   assign fault_n_out = fault_drive_r;
   assign fault_n_oe_n = fault_oe_n_r; // [RULE14]
endmodule // hbgc_top

// File: verif/hbgc_ctrl_model.sv
module hbgc_ctrl_model (
   // command: 0 low, 1 mid, 2 high, 3 released
   input wire logic [1:0] cmd,
   // comparator view of the pin
   output logic above_high,
   output logic below_low,
   output logic released
);
   timeunit 1ns;
   timeprecision 100ps;
   // a released pin settles at mid through the internal source
   assign above_high = (cmd == 2'h2);
   assign below_low = (cmd == 2'h0);
   assign released = (cmd == 2'h3);
endmodule // hbgc_ctrl_model

// File: verif/hbgc_properties.sv
module hbgc_properties (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // watched pins
   input wire logic enable,
   input wire logic logic_supply_good,
   input wire logic driver_supply_good,
   input wire logic ls_neg_limit,
   input wire logic over_temp,
   input wire logic phase_short,
   input wire logic high_side_switch_on,
   input wire logic low_side_switch_on,
   input wire logic mid_pull_en,
   input wire logic fault_n_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_dis; (!enable)[*5] |-> !high_side_switch_on && !low_side_switch_on; endproperty
   a_dis: assert property (p_dis) else $error("switch on while disabled");
   property p_sup; (!logic_supply_good || !driver_supply_good)[*5] |-> !high_side_switch_on && !low_side_switch_on;
   endproperty
   a_sup: assert property (p_sup) else $error("switch on with supply bad");
   property p_pull; mid_pull_en; endproperty
   a_pull: assert property (p_pull) else $error("mid source off");
   property p_neg; ls_neg_limit[*6] |-> !low_side_switch_on; endproperty
   a_neg: assert property (p_neg) else $error("low side on during limit");
   property p_blank; $fell(ls_neg_limit) |-> ##2 (!low_side_switch_on)[*8]; endproperty
   a_blank: assert property (p_blank) else $error("low side blank too short");
   property p_ot;
      high_side_switch_on ##1 (over_temp && enable && logic_supply_good && driver_supply_good)[*5]
         |-> !fault_n_oe_n && !high_side_switch_on;
   endproperty
   a_ot: assert property (p_ot) else $error("over temperature not latched");
   property p_short;
      high_side_switch_on ##1 (phase_short && enable && logic_supply_good && driver_supply_good)[*5]
         |-> !fault_n_oe_n && !high_side_switch_on;
   endproperty
   a_short: assert property (p_short) else $error("phase short not latched");
   property p_hold; (!fault_n_oe_n)[*2] |-> !high_side_switch_on; endproperty
   a_hold: assert property (p_hold) else $error("high side on while latched");
   c_hs: cover property (high_side_switch_on);
   c_ls: cover property (low_side_switch_on);
   c_flt: cover property (!fault_n_oe_n);
endmodule // hbgc_properties

bind hbgc_top hbgc_properties chk_i (.clock(clock), .rst(rst), .enable(enable),
   .logic_supply_good(logic_supply_good), .driver_supply_good(driver_supply_good), .ls_neg_limit(ls_neg_limit),
   .over_temp(over_temp), .phase_short(phase_short), .high_side_switch_on(high_side_switch_on),
   .low_side_switch_on(low_side_switch_on), .mid_pull_en(mid_pull_en), .fault_n_oe_n(fault_n_oe_n));

// File: verif/tb_half_bridge_gate_control.sv
module tb_half_bridge_gate_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, rst = 1'b1, enable = 1'b0, logic_supply_good = 1'b1, driver_supply_good = 1'b0;
   logic diode_emu_req_n = 1'b1, current_positive = 1'b0, current_negative = 1'b0, zero_cross = 1'b0;
   logic hs_over_current = 1'b0, ls_neg_limit = 1'b0, over_temp = 1'b0, phase_short = 1'b0;
   logic pwm_above_high, pwm_below_low, pwm_released, high_side_switch_on, low_side_switch_on;
   logic mid_pull_en, fault_n_out, fault_n_oe_n;
   logic [1:0] cmd = 2'h2;
   int fail_count = 0, num_checks = 0;
   wire [2:0] outs = {high_side_switch_on, low_side_switch_on, fault_n_oe_n};
   always #2.5 clock = ~clock;
   hbgc_ctrl_model pm (.cmd(cmd), .above_high(pwm_above_high), .below_low(pwm_below_low), .released(pwm_released));
   hbgc_top uut (.clock(clock), .rst(rst), .pwm_above_high(pwm_above_high), .pwm_below_low(pwm_below_low),
      .pwm_released(pwm_released), .enable(enable), .logic_supply_good(logic_supply_good),
      .driver_supply_good(driver_supply_good), .diode_emu_req_n(diode_emu_req_n),
      .current_positive(current_positive), .current_negative(current_negative), .zero_cross(zero_cross),
      .hs_over_current(hs_over_current), .ls_neg_limit(ls_neg_limit), .over_temp(over_temp),
      .phase_short(phase_short), .high_side_switch_on(high_side_switch_on),
      .low_side_switch_on(low_side_switch_on), .mid_pull_en(mid_pull_en), .fault_n_out(fault_n_out),
      .fault_n_oe_n(fault_n_oe_n));
   task cyc(input int n); repeat (n) @(posedge clock); #1; endtask
   task chk(input logic [2:0] got, input logic [2:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task t_run; enable = 1'b0; cyc(5); enable = 1'b1; cyc(6); endtask
   task t_start;
      enable = 1'b1; cyc(6); driver_supply_good = 1'b1; cyc(8);
      chk(outs, 3'b001);
      t_run; chk(outs, 3'b101);
      cmd = 2'h0; cyc(6); chk(outs, 3'b011);
   endtask
   task t_mid;
      cmd = 2'h2; current_positive = 1'b1; cyc(6); cmd = 2'h1; cyc(8);
      chk(outs, 3'b001);
      cmd = 2'h3; cyc(8); chk(outs, 3'b011);
      zero_cross = 1'b1; cyc(6); chk(outs, 3'b001);
      zero_cross = 1'b0; current_positive = 1'b0; cyc(4);
   endtask
   task t_de;
      cmd = 2'h0; diode_emu_req_n = 1'b0; current_positive = 1'b1; cyc(6); chk(outs, 3'b011);
      current_positive = 1'b0; current_negative = 1'b1; cyc(6); chk(outs, 3'b001);
      diode_emu_req_n = 1'b1; current_negative = 1'b0; cyc(6);
   endtask
   task t_neg;
      ls_neg_limit = 1'b1; cyc(2); ls_neg_limit = 1'b0; cyc(5); chk(outs, 3'b001);
      cyc(12); chk(outs, 3'b011);
   endtask
   task t_oc;
      for (int i = 0; i < 8; i++) begin
         cmd = 2'h2; cyc(4); hs_over_current = (i != 3); cyc(2); hs_over_current = 1'b0; cmd = 2'h0;
         if (i == 7) current_positive = 1'b1;
         cyc(6);
         if (i == 6) chk(outs, 3'b011);
      end
      chk(outs, 3'b010);
      zero_cross = 1'b1; cmd = 2'h2; cyc(6); chk(outs, 3'b000);
      zero_cross = 1'b0; current_positive = 1'b0; t_run; chk(outs, 3'b101);
   endtask
   task t_ot;
      over_temp = 1'b1; current_positive = 1'b1; cyc(6); chk(outs, 3'b010);
      over_temp = 1'b0; zero_cross = 1'b1; cyc(6); chk(outs, 3'b000);
      zero_cross = 1'b0; current_positive = 1'b0; t_run; chk(outs, 3'b101);
   endtask
   task t_short;
      phase_short = 1'b1; cyc(6); phase_short = 1'b0; cyc(6); chk(outs, 3'b000);
      logic_supply_good = 1'b0; cyc(6); chk(outs, 3'b001);
      logic_supply_good = 1'b1; t_run; chk(outs, 3'b101);
      enable = 1'b0; cyc(6); chk(outs, 3'b001);
      chk({1'b0, mid_pull_en, fault_n_out}, 3'b010);
   endtask
   initial begin
      cyc(3);
      rst = 1'b0;
      t_start;
      t_mid;
      t_de;
      t_neg;
      t_oc;
      t_ot;
      t_short;
      results;
   end
   initial begin
      #20000;
      fail_count++;
      results;
   end
endmodule // tb_half_bridge_gate_control
